// ==== logic/mmpc_top.sv ====
// Four-channel multi-mode pulse counter with an APB register slave.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mmpc_defines.svh"

module mmpc_top import mmpc_pkg::*;
#(
	parameter int GATE_BASE_TICKS = `MMPC_GATE_BASE_US
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [`MMPC_NUM_CH-1:0] counter_in_i,
	input wire logic [`MMPC_NUM_CH-1:0] phase2_in_i,
	input wire logic scan_strobe_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`MMPC_ADDR_W-1:0] paddr,
	input wire logic [`MMPC_DATA_W-1:0] pwdata,
	output logic [`MMPC_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************************************
	// Input conditioning
	// ****************************************************************
	logic active_low;
	mmpc_sense_t sense;

	// The polarity register drives the conditioner so every detector sees the active sense.
	mmpc_in_cond u_in_cond
	(
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.active_low_i(active_low),
		.pin_i({phase2_in_i, counter_in_i}),
		.sense_o(sense)
	);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire logic access_w;
	wire logic setup_w;
	wire logic wr_w;
	wire logic hi_zero_w;
	wire logic [3:0] blk_w;
	wire logic [1:0] word_w;
	wire logic is_ctrl_w;
	wire logic is_status_w;
	wire logic is_ch_w;
	wire logic [1:0] ch_idx_w;
	wire logic mapped_w;

	// The slave never stalls on its own; a low clock enable holds the transfer instead.
	assign pready = ce_i;
	assign access_w = psel & penable & ce_i;
	assign setup_w = psel & ~penable & ce_i;
	assign wr_w = access_w & pwrite;
	assign hi_zero_w = (paddr[`MMPC_ADDR_W-1:8] == '0);
	assign blk_w = paddr[7:4];
	assign word_w = paddr[3:2];
	assign is_ctrl_w = hi_zero_w & ({paddr[7:2], 2'h0} == {4'h0, `MMPC_OFF_CTRL});
	assign is_status_w = hi_zero_w & ({paddr[7:2], 2'h0} == {4'h0, `MMPC_OFF_STATUS});
	assign is_ch_w = hi_zero_w & (blk_w >= `MMPC_CH_FIRST) & (blk_w <= `MMPC_CH_LAST)
		& (word_w != 2'h3);
	assign ch_idx_w = 2'(blk_w - `MMPC_CH_FIRST);
	assign mapped_w = is_ctrl_w | is_status_w | is_ch_w;
	assign pslverr = psel & penable & ~mapped_w;

	// ****************************************************************
	// Microsecond tick and gate time base
	// ****************************************************************
	logic [6:0] tick_cnt;
	logic [13:0] base_cnt;
	logic [3:0] g100_cnt;
	logic [3:0] g1s_cnt;
	wire logic tick_w;
	wire logic g10_w;
	wire logic g100_w;
	wire logic g1s_w;
	wire logic [3:0] gate_w;

	assign tick_w = ce_i & (tick_cnt == 7'(`MMPC_TICK_CYCLES - 1));
	assign g10_w = tick_w & (base_cnt == 14'(GATE_BASE_TICKS - 1));
	assign g100_w = g10_w & (g100_cnt == 4'(`MMPC_GATE_RATIO_100MS - 1));
	assign g1s_w = g100_w & (g1s_cnt == 4'(`MMPC_GATE_RATIO_1S - 1));
	// Gate index follows the frequency mode: 1 s, 100 ms, 10 ms, then scan strobe.
	assign gate_w = {ce_i & scan_strobe_i, g10_w, g100_w, g1s_w};

	// Cascaded dividers share one time base so all gates stay aligned.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick_cnt <= 7'h00;
			base_cnt <= 14'h0000;
			g100_cnt <= 4'h0;
			g1s_cnt <= 4'h0;
		end
		else if (ce_i)
		begin
			tick_cnt <= tick_w ? 7'h00 : tick_cnt + 7'h01;
			if (tick_w)
				base_cnt <= g10_w ? 14'h0000 : base_cnt + 14'h0001;
			if (g10_w)
				g100_cnt <= g100_w ? 4'h0 : g100_cnt + 4'h1;
			if (g100_w)
				g1s_cnt <= g1s_w ? 4'h0 : g1s_cnt + 4'h1;
		end
	end

	// ****************************************************************
	// Marker logic for the quadrature channel
	// ****************************************************************
	mmpc_cfg_t cfg_w [0:`MMPC_NUM_CH-1];
	logic [31:0] cpr_w [0:`MMPC_NUM_CH-1];
	logic [31:0] res_w [0:`MMPC_NUM_CH-1];
	wire logic [`MMPC_NUM_CH-1:0] refuse_w;
	wire logic marker_on_w;
	wire logic [3:0] mk_mode_w;
	wire logic [2:0] mk_q_w;
	wire logic mk_lvl_ok_w;
	wire logic mk_ph_edge_w;
	wire logic mk_async_w;
	wire logic mk_qual_w;
	wire logic marker_hit_w;

	// Marker only acts while its pairing with the quadrature channel still holds.
	assign marker_on_w = (cfg_w[`MMPC_MARKER_CH].ctype == MMPC_MARKER)
		& (cfg_w[`MMPC_QUAD_CH].ctype == MMPC_QUAD);
	assign mk_mode_w = cfg_w[`MMPC_MARKER_CH].mode;
	assign mk_q_w = 3'(mk_mode_w - `MMPC_MODE_QUAL_FIRST);
	// Asynchronous modes look at marker edges only, whatever the phases do.
	assign mk_async_w = (mk_mode_w == 4'h0) ? sense.rise[`MMPC_MARKER_CH] :
		(mk_mode_w == 4'h1) ? sense.fall[`MMPC_MARKER_CH] :
		(mk_mode_w == `MMPC_MODE_ASYNC_LAST) ?
		(sense.rise[`MMPC_MARKER_CH] | sense.fall[`MMPC_MARKER_CH]) : 1'b0;
	// Qualified: bit 0 picks low level, bit 1 falling edge, bit 2 phase 2.
	assign mk_lvl_ok_w = mk_q_w[0] ^ sense.level[`MMPC_MARKER_CH];
	assign mk_ph_edge_w = mk_q_w[2] ?
		(mk_q_w[1] ? sense.fall[`MMPC_QUAD_CH + `MMPC_NUM_CH] :
		sense.rise[`MMPC_QUAD_CH + `MMPC_NUM_CH]) :
		(mk_q_w[1] ? sense.fall[`MMPC_QUAD_CH] : sense.rise[`MMPC_QUAD_CH]);
	assign mk_qual_w = (mk_mode_w >= `MMPC_MODE_QUAL_FIRST) & (mk_mode_w <= `MMPC_MODE_QUAL_LAST)
		& mk_lvl_ok_w & mk_ph_edge_w;
	assign marker_hit_w = marker_on_w & (mk_async_w | mk_qual_w);

	// ****************************************************************
	// Counter channels
	// ****************************************************************
	genvar c;
	generate
		for (c = 0; c < `MMPC_NUM_CH; c++)
		begin : g_ch
			mmpc_cfg_t cfg;
			logic [31:0] cpr;
			logic [31:0] cnt;
			logic [31:0] res;
			logic [31:0] next_cnt;
			logic [31:0] next_res;
			wire logic sel_w;
			wire logic cfg_wr_w;
			wire logic cpr_wr_w;
			wire mmpc_type_t new_type_w;
			wire logic bad_type_w;
			wire logic a_lvl_w;
			wire logic a_rise_w;
			wire logic a_fall_w;
			wire logic b_lvl_w;
			wire logic b_chg_w;
			wire logic b_prev_w;
			wire logic q_step_w;
			wire logic q_up_w;
			wire logic clr_w;

			assign sel_w = is_ch_w & (ch_idx_w == 2'(c));
			assign cfg_wr_w = wr_w & sel_w & (word_w == `MMPC_CH_CFG);
			assign cpr_wr_w = wr_w & sel_w & (word_w == `MMPC_CH_CPR);
			assign new_type_w = mmpc_type_t'(pwdata[`MMPC_CFG_TYPE_LSB +: 3]);
			// Unknown types and a misplaced marker are refused; the old setting stays.
			assign bad_type_w = (new_type_w > MMPC_MARKER) | ((new_type_w == MMPC_MARKER)
				& ((c != `MMPC_MARKER_CH) | (cfg_w[`MMPC_QUAD_CH].ctype != MMPC_QUAD)));
			assign refuse_w[c] = cfg_wr_w & bad_type_w;

			assign a_lvl_w = sense.level[c];
			assign a_rise_w = sense.rise[c];
			assign a_fall_w = sense.fall[c];
			assign b_lvl_w = sense.level[c + `MMPC_NUM_CH];
			assign b_chg_w = sense.rise[c + `MMPC_NUM_CH] | sense.fall[c + `MMPC_NUM_CH];
			assign b_prev_w = b_lvl_w ^ b_chg_w;
			// Four edges per cycle; up when phase 1 leads, unless mode bit 0 reverses it.
			assign q_step_w = a_rise_w | a_fall_w | b_chg_w;
			assign q_up_w = a_lvl_w ^ b_prev_w ^ cfg.mode[0];
			assign clr_w = (c == `MMPC_QUAD_CH) ? marker_hit_w : 1'b0;

			// Next count and result by type; each type reads its own fields only.
			always_comb
			begin
				next_cnt = cnt;
				next_res = res;
				case (cfg.ctype)
					MMPC_FREQ:
					begin
						if (gate_w[cfg.mode[1:0]])
						begin
							next_res = cnt;
							next_cnt = {31'h0, a_rise_w};
						end
						else if (a_rise_w)
							next_cnt = cnt + 32'h1;
					end
					MMPC_TOTAL:
					begin
						if (cfg.mode[0] ? a_fall_w : a_rise_w)
							next_cnt = mmpc_step(cnt, cpr, 1'b1);
						next_res = next_cnt;
					end
					MMPC_PULSE:
					begin
						case (cfg.mode[1:0])
							2'h0:
							begin
								if (a_fall_w)
								begin
									next_res = cnt;
									next_cnt = 32'h0;
								end
								else if (a_lvl_w & tick_w)
									next_cnt = cnt + 32'h1;
							end
							2'h1:
							begin
								if (a_rise_w)
								begin
									next_res = cnt;
									next_cnt = 32'h0;
								end
								else if (~a_lvl_w & tick_w)
									next_cnt = cnt + 32'h1;
							end
							default:
							begin
								if (cfg.mode[0] ? a_fall_w : a_rise_w)
								begin
									next_res = cnt;
									next_cnt = 32'h0;
								end
								else if (tick_w)
									next_cnt = cnt + 32'h1;
							end
						endcase
					end
					MMPC_QUAD:
					begin
						if (clr_w)
							next_cnt = 32'h0;
						else if (q_step_w)
							next_cnt = mmpc_step(cnt, cpr, q_up_w);
						next_res = next_cnt;
					end
					MMPC_MARKER:
					begin
						if (marker_hit_w)
							next_cnt = cnt + 32'h1;
						next_res = next_cnt;
					end
					default:
					begin
						next_cnt = 32'h0;
						next_res = 32'h0;
					end
				endcase
			end

			// Accepted configuration writes restart the measurement from zero.
			always_ff @(posedge clock_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					cfg <= '{mode: 4'h0, ctype: MMPC_DISABLED};
					cpr <= `MMPC_CPR_RST;
					cnt <= 32'h0;
					res <= 32'h0;
				end
				else if (ce_i)
				begin
					if (cfg_wr_w & ~bad_type_w)
					begin
						cfg <= '{mode: pwdata[`MMPC_CFG_MODE_LSB +: 4], ctype: new_type_w};
						cnt <= 32'h0;
						res <= 32'h0;
					end
					else
					begin
						cnt <= next_cnt;
						res <= next_res;
					end
					if (cpr_wr_w)
						cpr <= pwdata;
				end
			end

			assign cfg_w[c] = cfg;
			assign cpr_w[c] = cpr;
			assign res_w[c] = res;
		end
	endgenerate

	// ****************************************************************
	// Control and status registers
	// ****************************************************************
	logic refused;
	wire logic [`MMPC_DATA_W-1:0] ctrl_rd_w;
	wire logic [`MMPC_DATA_W-1:0] status_rd_w;
	wire logic [`MMPC_DATA_W-1:0] ch_rd_w;
	wire logic [`MMPC_DATA_W-1:0] rd_w;
	wire logic refused_clr_w;

	assign refused_clr_w = wr_w & is_status_w & pwdata[`MMPC_STATUS_REFUSED_BIT];

	// A refusal in the same cycle as the clear wins, so no refusal goes unseen.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			active_low <= 1'b0;
			refused <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_w & is_ctrl_w)
				active_low <= pwdata[`MMPC_CTRL_POL_BIT];
			refused <= (|refuse_w) | (refused & ~refused_clr_w);
		end
	end

	// Inputs stay readable as plain discrete levels whatever the counter type.
	assign ctrl_rd_w = `MMPC_DATA_W'(active_low) << `MMPC_CTRL_POL_BIT;
	assign status_rd_w = (`MMPC_DATA_W'(refused) << `MMPC_STATUS_REFUSED_BIT)
		| (`MMPC_DATA_W'(sense.level) << `MMPC_STATUS_LVL_LSB);
	assign ch_rd_w = (word_w == `MMPC_CH_CFG) ? ((`MMPC_DATA_W'(cfg_w[ch_idx_w].mode)
		<< `MMPC_CFG_MODE_LSB) | (`MMPC_DATA_W'(cfg_w[ch_idx_w].ctype) << `MMPC_CFG_TYPE_LSB)) :
		(word_w == `MMPC_CH_CPR) ? cpr_w[ch_idx_w] : res_w[ch_idx_w];
	assign rd_w = is_ctrl_w ? ctrl_rd_w : is_status_w ? status_rd_w :
		is_ch_w ? ch_rd_w : '0;

	// Read data is captured in the setup cycle and stands through the access phase.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			prdata <= '0;
		else if (setup_w)
			prdata <= pwrite ? '0 : rd_w;
	end

endmodule

// ==== logic/mmpc_defines.svh ====
// Constants for the multi-mode pulse counter: sizes, timing, register map and field positions.
`ifndef MMPC_DEFINES_SVH
`define MMPC_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define MMPC_NUM_CH 4
`define MMPC_NUM_PINS 8
`define MMPC_DATA_W 32
`define MMPC_ADDR_W 12

// ****************************************************************
// Timing
// ****************************************************************
`define MMPC_CLK_MHZ 100
`define MMPC_TICK_NS 1000
`define MMPC_TICK_CYCLES ((`MMPC_TICK_NS * `MMPC_CLK_MHZ) / 1000)
`define MMPC_GATE_10MS_MS 10
`define MMPC_GATE_100MS_MS 100
`define MMPC_GATE_1S_MS 1000
`define MMPC_GATE_BASE_US (`MMPC_GATE_10MS_MS * 1000)
`define MMPC_GATE_RATIO_100MS (`MMPC_GATE_100MS_MS / `MMPC_GATE_10MS_MS)
`define MMPC_GATE_RATIO_1S (`MMPC_GATE_1S_MS / `MMPC_GATE_100MS_MS)

// ****************************************************************
// Register map (byte offsets) and fields
// ****************************************************************
`define MMPC_OFF_CTRL 4'h0
`define MMPC_OFF_STATUS 4'h4
`define MMPC_CH_FIRST 4'h1
`define MMPC_CH_LAST 4'h4
`define MMPC_CH_CFG 2'h0
`define MMPC_CH_CPR 2'h1
`define MMPC_CH_RESULT 2'h2
`define MMPC_CTRL_POL_BIT 0
`define MMPC_STATUS_LVL_LSB 0
`define MMPC_STATUS_REFUSED_BIT 8
`define MMPC_CFG_TYPE_LSB 0
`define MMPC_CFG_MODE_LSB 4
`define MMPC_CPR_RST 32'h0000_0000
`define MMPC_MARKER_CH 2
`define MMPC_QUAD_CH 0
`define MMPC_MODE_ASYNC_LAST 4'h2
`define MMPC_MODE_QUAL_FIRST 4'h3
`define MMPC_MODE_QUAL_LAST 4'hA

`endif

// ==== logic/mmpc_pkg.sv ====
// Types shared by the multi-mode pulse counter modules.
`include "mmpc_defines.svh"

package mmpc_pkg;

	typedef enum logic [2:0]
	{
		MMPC_DISABLED = 3'h0,
		MMPC_FREQ = 3'h1,
		MMPC_TOTAL = 3'h2,
		MMPC_PULSE = 3'h3,
		MMPC_QUAD = 3'h4,
		MMPC_MARKER = 3'h5
	} mmpc_type_t;

	typedef struct packed
	{
		logic [3:0] mode;
		mmpc_type_t ctype;
	} mmpc_cfg_t;

	typedef struct packed
	{
		logic [`MMPC_NUM_PINS-1:0] level;
		logic [`MMPC_NUM_PINS-1:0] rise;
		logic [`MMPC_NUM_PINS-1:0] fall;
	} mmpc_sense_t;

	// Up/down step with optional wrap at a nonzero limit; zero limit runs free.
	function automatic logic [31:0] mmpc_step(input logic [31:0] v, input logic [31:0] lim,
		input logic up);
		logic [31:0] r;
		r = v;
		if (up)
			r = (lim != 32'h0 && v == lim - 32'h1) ? 32'h0 : v + 32'h1;
		else if (v == 32'h0)
			r = (lim != 32'h0) ? lim - 32'h1 : 32'hFFFF_FFFF;
		else
			r = v - 32'h1;
		return r;
	endfunction

endpackage

// ==== logic/mmpc_in_cond.sv ====
// Input conditioner: pin synchroniser, polarity and edge detection per input.
`timescale 1ns/1ps
`include "mmpc_defines.svh"

module mmpc_in_cond import mmpc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic active_low_i,
	input wire logic [`MMPC_NUM_PINS-1:0] pin_i,
	output mmpc_sense_t sense_o
);

	// ****************************************************************
	// Per-pin synchroniser and edge detector
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < `MMPC_NUM_PINS; g++)
		begin : g_pin
			logic sync1;
			logic sync2;
			logic prev;
			wire logic lvl;

			// Polarity is applied after the second stage so edges follow the active sense.
			assign lvl = sync2 ^ active_low_i;

			// Two stages keep metastability away from the edge logic.
			always_ff @(posedge clock_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					sync1 <= 1'b0;
					sync2 <= 1'b0;
					prev <= 1'b0;
				end
				else if (ce_i)
				begin
					sync1 <= pin_i[g];
					sync2 <= sync1;
					prev <= lvl;
				end
			end

			assign sense_o.level[g] = lvl;
			assign sense_o.rise[g] = ce_i & lvl & ~prev;
			assign sense_o.fall[g] = ce_i & ~lvl & prev;
		end
	endgenerate

endmodule

// ==== testbench/mmpc_top_chk.sv ====
// Checker for the pulse counter register port, bound to the top module.
`timescale 1ns/1ps
module mmpc_top_chk
#(
	parameter int GATE_BASE_TICKS = 10000
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ****
	// Shadows
	// ****
	logic pol_q;
	logic [31:0] cpr0_q;
	logic [2:0] type3_q;
	wire logic [9:0] widx = paddr[11:2];
	wire logic mapped = widx < 10'h2 || (widx > 10'h3 && widx < 10'h14 && widx[1:0] != 2'h3);
	wire logic take = psel && penable && ce_i && pwrite;

	// Track what software wrote; a refused type never reaches the copy.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pol_q <= 1'b0;
			cpr0_q <= 32'h0;
			type3_q <= 3'h0;
		end
		else if (take)
		begin
			if (paddr == 12'h000)
				pol_q <= pwdata[0];
			if (paddr == 12'h014)
				cpr0_q <= pwdata;
			if (paddr == 12'h040 && pwdata[2:0] < 3'h5)
				type3_q <= pwdata[2:0];
		end
	end

	// ****
	// Properties
	// ****
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	ready_ce_a: assert property (pready == ce_i)
		else $error("pready does not follow ce_i");
	err_map_a: assert property (pslverr == (psel && penable && !mapped))
		else $error("pslverr disagrees with the address map");
	err_zero_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("unmapped access returned data");
	rd_hold_a: assert property (!psel && $past(!psel) |-> $stable(prdata))
		else $error("read data moved while idle");
	wr_zero_a: assert property (psel && !penable && pwrite && ce_i |=> prdata == 32'h0)
		else $error("write returned nonzero data");
	pol_read_a: assert property (psel && !penable && ce_i && !pwrite && paddr == 12'h000
		|=> prdata == {31'h0, pol_q}) else $error("polarity readback wrong");
	cpr_read_a: assert property (psel && !penable && ce_i && !pwrite && paddr == 12'h014
		|=> prdata == cpr0_q) else $error("count limit readback wrong");
	dis_zero_a: assert property (psel && !penable && ce_i && !pwrite && paddr == 12'h048
		&& type3_q == 3'h0 |=> prdata == 32'h0) else $error("disabled channel counted");

	cov_err: cover property (psel && penable && pslverr);
	cov_cfg: cover property (take && paddr == 12'h030);
	cov_rd: cover property (psel && penable && !pwrite && prdata != 32'h0);
endmodule

// ==== testbench/mmpc_src.sv ====
// Pulse source model for the counter and phase-2 pins of four channels.
`timescale 1ns/1ps
module mmpc_src
(
	input wire logic clock_i,
	output logic [3:0] counter_o,
	output logic [3:0] phase2_o
);
	// Pins idle low; every change lands just after a rising edge.
	initial
	begin
		counter_o = 4'h0;
		phase2_o = 4'h0;
	end

	// Holds are two clocks or more so the synchroniser never drops a level.
	task automatic level(input int ch, input logic v, input int hold);
		counter_o[ch] <= v;
		repeat (hold) @(posedge clock_i);
	endtask

	// Whole pulses, high for hi clocks then low for lo clocks.
	task automatic pulse(input int ch, input int n, input int hi, input int lo);
		repeat (n)
		begin
			level(ch, 1'b1, hi);
			level(ch, 1'b0, lo);
		end
	endtask

	// One full cycle of four edges; phase 1 leads when fwd is set.
	task automatic quad(input int ch, input logic fwd);
		for (int i = 0; i < 4; i++)
		begin
			counter_o[ch] <= fwd ? (i < 2) : (i == 1 || i == 2);
			phase2_o[ch] <= fwd ? (i == 1 || i == 2) : (i < 2);
			repeat (4) @(posedge clock_i);
		end
	endtask
endmodule

// ==== testbench/tb_mmpc_top.sv ====
// Self-checking bench for the four-channel pulse counter and its register port.
`timescale 1ns/1ps
module tb_mmpc_top import mmpc_pkg::*;
;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} mmpc_row_t;
	logic clock_i;
	logic reset_n_i;
	logic ce_i;
	logic scan_strobe_i;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] pin_main;
	logic [3:0] pin_ph2;
	logic [31:0] r;
	logic e;
	int err_count;
	int checked;
	int pw_exp [4] = '{3, 4, 7, 7};
	logic [31:0] mk_exp [6] = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h0, 32'h1};
	mmpc_row_t rows [7] = '{
		'{12'h014, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'h0},
		'{12'h044, 32'h1234_5678, 32'h1234_5678, 1'h0},
		'{12'h018, 32'h5, 32'h0, 1'h0},
		'{12'h020, 32'h12, 32'h12, 1'h0},
		'{12'h01C, 32'h7, 32'h0, 1'h1},
		'{12'h050, 32'h7, 32'h0, 1'h1},
		'{12'h040, 32'h17, 32'h0, 1'h0}};

	mmpc_src u_src (.clock_i(clock_i), .counter_o(pin_main), .phase2_o(pin_ph2));

	mmpc_top #(.GATE_BASE_TICKS(10)) u_dut
	(
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.counter_in_i(pin_main),
		.phase2_in_i(pin_ph2),
		.scan_strobe_i(scan_strobe_i),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ****
	// Helpers
	// ****
	task automatic give_verdict();
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		if (n >= 100)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: no pready", $time);
			give_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk({31'h0, e}, 32'h0);
	endtask

	// Tick-based results may land one tick either side of the ideal figure.
	task automatic near(input logic [11:0] a, input int x);
		apb(1'b0, a, 32'h0);
		checked++;
		if (^r === 1'bx || r > x + 1 || r + 1 < x)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h, near %0d", $time, r, x);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic strobe();
		scan_strobe_i <= 1'b1;
		@(posedge clock_i);
		scan_strobe_i <= 1'b0;
		@(posedge clock_i);
	endtask

	function automatic logic [11:0] ra(input int ch, input int k);
		return 12'h010 + 12'(ch * 16 + k * 4);
	endfunction

	function automatic logic [31:0] cf(input logic [3:0] m, input mmpc_type_t t);
		return {24'h0, m, 1'h0, t};
	endfunction

	// ****
	// Stimulus
	// ****
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Watchdog so a stuck design still reaches the verdict.
	initial
	begin
		repeat (80000) @(posedge clock_i);
		err_count++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		give_verdict();
	end

	initial
	begin
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		scan_strobe_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		err_count = 0;
		checked = 0;
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(posedge clock_i);
		rd(12'h004, 32'h0);
		for (int k = 0; k < 3; k++)
			rd(ra(0, k), 32'h0);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk({31'h0, e}, {31'h0, rows[i].e});
			apb(1'b0, rows[i].a, 32'h0);
			chk(r, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		// The refused type on channel 3 left the sticky flag; writing one clears it.
		rd(12'h004, 32'h0000_0100);
		wr(12'h004, 32'h0000_0100);
		rd(12'h004, 32'h0);
		wr(12'h000, 32'h1);
		idle(6);
		rd(12'h004, 32'h0000_00FF);
		wr(12'h000, 32'h0);
		u_src.level(3, 1'b1, 6);
		rd(12'h004, 32'h0000_0008);
		u_src.pulse(3, 3, 3, 3);
		rd(ra(3, 2), 32'h0);
		wr(ra(0, 1), 32'h3);
		wr(ra(0, 0), cf(4'h0, MMPC_TOTAL));
		u_src.pulse(0, 4, 3, 3);
		idle(4);
		rd(ra(0, 2), 32'h1);
		wr(ra(1, 0), cf(4'h1, MMPC_TOTAL));
		u_src.level(1, 1'b1, 6);
		rd(ra(1, 2), 32'h0);
		u_src.level(1, 1'b0, 6);
		rd(ra(1, 2), 32'h1);
		// Pulses that come and go while the clock enable is low must leave no count.
		ce_i <= 1'b0;
		u_src.pulse(1, 2, 3, 3);
		ce_i <= 1'b1;
		rd(ra(1, 2), 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			wr(ra(2, 0), cf(4'(m), MMPC_PULSE));
			u_src.pulse(2, 3, 300, 400);
			near(ra(2, 2), pw_exp[m]);
		end
		// Marker is refused while channel 0 is not in quadrature.
		wr(ra(2, 0), cf(4'h0, MMPC_MARKER));
		rd(ra(2, 0), cf(4'h3, MMPC_PULSE));
		rd(12'h004, 32'h0000_0100);
		wr(12'h004, 32'h0000_0100);
		wr(ra(1, 0), cf(4'h3, MMPC_FREQ));
		strobe();
		u_src.pulse(1, 5, 3, 3);
		idle(4);
		strobe();
		idle(4);
		rd(ra(1, 2), 32'h5);
		for (int m = 1; m < 3; m++)
		begin
			wr(ra(1, 0), cf(4'(m), MMPC_FREQ));
			u_src.pulse(1, m == 1 ? 440 : 60, 25, 25);
			near(ra(1, 2), m == 1 ? 200 : 20);
		end
		wr(ra(0, 1), 32'h0);
		wr(ra(0, 0), cf(4'h1, MMPC_QUAD));
		u_src.quad(0, 1'b1);
		idle(4);
		rd(ra(0, 2), 32'hFFFF_FFFC);
		wr(ra(0, 0), cf(4'h0, MMPC_QUAD));
		// The last pass uses a qualified mode on the falling edge of phase 2.
		for (int m = 0; m < 6; m++)
		begin
			u_src.quad(0, 1'b1);
			wr(ra(2, 0), cf(m < 5 ? 4'(m) : 4'h9, MMPC_MARKER));
			if (m < 3)
				u_src.pulse(2, 1, 6, 6);
			else
			begin
				u_src.level(2, 1'b1, 4);
				u_src.quad(0, 1'b1);
				u_src.level(2, 1'b0, 6);
			end
			if (m < 3)
				rd(ra(0, 2), 32'h0);
			rd(ra(2, 2), mk_exp[m]);
		end
		// A reset in mid-run must bring every setting back to its idle value.
		reset_n_i <= 1'b0;
		idle(3);
		reset_n_i <= 1'b1;
		idle(1);
		rd(12'h000, 32'h0);
		rd(ra(0, 0), 32'h0);
		rd(ra(0, 2), 32'h0);
		give_verdict();
	end
endmodule

bind mmpc_top mmpc_top_chk #(.GATE_BASE_TICKS(GATE_BASE_TICKS)) u_chk
(
	.clock_i(clock_i),
	.reset_n_i(reset_n_i),
	.ce_i(ce_i),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);
